// ### rtl/flash_ctrl_pkg.sv
// Purpose: constants and types for the flash and video light controller
// Assumes: 20 MHz pclk, APB register access
// Notes:   register offsets are byte addresses
package flash_ctrl_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned WDOG_SECONDS    = 13;
    localparam longint unsigned WDOG_CYCLES =
        longint'(WDOG_SECONDS) * longint'(CLK_HZ);
    // flash time step for the short and long range, in microseconds
    localparam int unsigned FLASH_STEP_SHORT_US = 100;
    localparam int unsigned FLASH_STEP_LONG_US  = 1000;
    localparam int unsigned FLASH_STEP_SHORT_CYC =
        (FLASH_STEP_SHORT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FLASH_STEP_LONG_CYC =
        (FLASH_STEP_LONG_US * (CLK_HZ / 1_000_000));

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TORCH   = 8'h00;
    localparam logic [7:0] ADDR_MODE    = 8'h04;
    localparam logic [7:0] ADDR_FLASHC  = 8'h08;
    localparam logic [7:0] ADDR_TIMING  = 8'h0c;
    localparam logic [7:0] ADDR_VOLT    = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;

    // field positions
    localparam int unsigned MODE_LSB    = 6;
    localparam int unsigned FORCE_BIT   = 0;
    localparam int unsigned SOFT_BIT    = 7;
    localparam int unsigned TTYPE_BIT   = 4;
    localparam int unsigned RANGE_BIT   = 3;
    localparam int unsigned FCOUT_LSB   = 8;

    // reset values
    localparam logic [2:0] RST_TORCH_OUTER  = 3'h2;
    localparam logic [2:0] RST_TORCH_CENTRE = 3'h2;
    localparam logic [5:0] RST_FLASH_CENTRE = 6'h10;
    localparam logic [4:0] RST_FLASH_OUTER  = 5'h08;
    localparam logic [2:0] RST_FLASH_TIME   = 3'h4;
    localparam logic [3:0] RST_VOLT_CODE    = 4'h6;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_VIDEO    = 2'b01,
        MODE_FLASH    = 2'b10,
        MODE_VOLTAGE  = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EDGE  = 2'b01,
        ST_LEVEL = 2'b10
    } flash_state_t;

    typedef struct packed {
        logic [2:0] torch_current_outer;
        logic [2:0] torch_current_centre;
        logic [5:0] flash_current_centre;
        logic [4:0] flash_current_outer;
    } current_t;

    typedef struct packed {
        logic       shutdown;
        logic       voltage_regulation_state;
        logic       torch_on;
        logic       flash_on;
        logic [3:0] output_voltage_code;
    } drive_t;

endpackage : flash_ctrl_pkg

// ### rtl/led_flash_mode_control.sv
// Purpose: mode, trigger and timer control for a boosted LED driver
// Assumes: strobe pins asynchronous to pclk; APB master per protocol
// Notes:   analog regulation lies outside; outputs are control levels
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps

module led_flash_mode_control #(
    parameter longint unsigned WDOG_LIMIT = flash_ctrl_pkg::WDOG_CYCLES,
    parameter int unsigned     STEP_SHORT = flash_ctrl_pkg::FLASH_STEP_SHORT_CYC,
    parameter int unsigned     STEP_LONG  = flash_ctrl_pkg::FLASH_STEP_LONG_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  trigger_strobe_in,
    input  wire logic                  select_strobe_in,
    output flash_ctrl_pkg::current_t   currents,
    output flash_ctrl_pkg::drive_t     drive
);
    import flash_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    current_t     cur;
    mode_t        mode;
    logic         force_voltage_mode;
    logic         soft_flash_start;
    logic         trigger_type_sel;
    logic         flash_time_range_sel;
    logic [2:0]   flash_time_field;
    logic [3:0]   output_voltage_code;
    logic         timeout_flag;
    logic         wdog_expired;

    // ------------------------------------------------------------------
    // strobe synchronisers
    // ------------------------------------------------------------------
    logic [1:0]   trig_sync;
    logic [1:0]   sel_sync;
    logic         trig_prev;
    logic         soft_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sync <= 2'b00;
            sel_sync  <= 2'b00;
        end else begin
            trig_sync <= {trig_sync[0], trigger_strobe_in};
            sel_sync  <= {sel_sync[0], select_strobe_in};
        end
    end

    wire trig_s = trig_sync[1];
    wire sel_s  = sel_sync[1];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire hit_tor  = (paddr == ADDR_TORCH);
    wire hit_mode = (paddr == ADDR_MODE);
    wire hit_fc   = (paddr == ADDR_FLASHC);
    wire hit_tim  = (paddr == ADDR_TIMING);
    wire hit_volt = (paddr == ADDR_VOLT);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire mapped   = hit_tor | hit_mode | hit_fc | hit_tim | hit_volt
                  | hit_stat;
    wire wr_mode  = wr && hit_mode;

    // ------------------------------------------------------------------
    // flash sequencing
    // ------------------------------------------------------------------
    flash_state_t state;
    flash_state_t next_state;
    logic [15:0]  step_cnt;
    logic [2:0]   step_left;
    logic [35:0]  wdog_cnt;

    wire strobes_on = (mode == MODE_FLASH);
    wire trig_rise  = strobes_on && trig_s && !trig_prev;
    wire soft_rise  = strobes_on && soft_flash_start && !soft_prev;
    wire flash_trig = trig_rise && !sel_s;
    wire step_end   = flash_time_range_sel ?
                      (step_cnt == 16'(STEP_LONG - 1)) :
                      (step_cnt == 16'(STEP_SHORT - 1));
    wire running    = (state != ST_IDLE);
    wire time_up    = running && step_end && (step_left == 3'h0);
    wire level_drop = (state == ST_LEVEL) && (!trig_s || sel_s
                      || !strobes_on);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (soft_rise || (flash_trig && trigger_type_sel))
                    next_state = ST_EDGE;
                else if (flash_trig)
                    next_state = ST_LEVEL;
            end
            ST_EDGE: begin
                if (time_up || !strobes_on)
                    next_state = ST_IDLE;
            end
            ST_LEVEL: begin
                if (time_up || level_drop)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    wire starting = (state == ST_IDLE) && (next_state != ST_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            step_cnt  <= 16'h0000;
            step_left <= 3'h0;
            trig_prev <= 1'b0;
            soft_prev <= 1'b0;
        end else begin
            state     <= next_state;
            trig_prev <= trig_s;
            soft_prev <= soft_flash_start;
            if (starting || step_end)
                step_cnt <= 16'h0000;
            else
                step_cnt <= step_cnt + 16'h0001;
            if (starting)
                step_left <= flash_time_field;
            else if (running && step_end && step_left != 3'h0)
                step_left <= step_left - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // video watchdog
    // ------------------------------------------------------------------
    // watchdog in mode 01 only
    wire wdog_run = (mode == MODE_VIDEO) && !sel_s && !wdog_expired;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt     <= 36'h0;
            wdog_expired <= 1'b0;
        end else if (wr_mode || !wdog_run) begin
            wdog_cnt <= 36'h0;
            if (wr_mode)
                wdog_expired <= 1'b0;
        end else if (wdog_cnt == 36'(WDOG_LIMIT - 1)) begin
            wdog_expired <= 1'b1;
        end else begin
            wdog_cnt <= wdog_cnt + 36'h1;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // current fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.torch_current_outer  <= RST_TORCH_OUTER;
            cur.torch_current_centre <= RST_TORCH_CENTRE;
            cur.flash_current_centre <= RST_FLASH_CENTRE;
            cur.flash_current_outer  <= RST_FLASH_OUTER;
        end else begin
            if (wr && hit_tor) begin
                cur.torch_current_outer  <= pwdata[5:3];
                cur.torch_current_centre <= pwdata[2:0];
            end
            if (wr && hit_fc) begin
                cur.flash_current_centre <= pwdata[5:0];
                cur.flash_current_outer  <= pwdata[FCOUT_LSB +: 5];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode                 <= MODE_SHUTDOWN;
            force_voltage_mode   <= 1'b0;
            trigger_type_sel     <= 1'b0;
            flash_time_range_sel <= 1'b0;
            flash_time_field     <= RST_FLASH_TIME;
            output_voltage_code  <= RST_VOLT_CODE;
        end else begin
            if (wr_mode) begin
                mode               <= mode_t'(pwdata[MODE_LSB +: 2]);
                force_voltage_mode <= pwdata[FORCE_BIT];
            end
            if (wr && hit_tim) begin
                trigger_type_sel     <= pwdata[TTYPE_BIT];
                flash_time_range_sel <= pwdata[RANGE_BIT];
                flash_time_field     <= pwdata[2:0];
            end
            if (wr && hit_volt)
                output_voltage_code <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            soft_flash_start <= 1'b0;
        else if (time_up)
            soft_flash_start <= 1'b0;
        else if (wr && hit_tim)
            soft_flash_start <= pwdata[SOFT_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timeout_flag <= 1'b0;
        else if (time_up)
            timeout_flag <= 1'b1;
        else if (starting)
            timeout_flag <= 1'b0;
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire [31:0] rd_mux =
        hit_tor  ? {26'h0, cur.torch_current_outer,
                    cur.torch_current_centre} :
        hit_mode ? {24'h0, mode, 5'h0, force_voltage_mode} :
        hit_fc   ? {19'h0, cur.flash_current_outer, 2'h0,
                    cur.flash_current_centre} :
        hit_tim  ? {24'h0, soft_flash_start, 2'h0, trigger_type_sel,
                    flash_time_range_sel, flash_time_field} :
        hit_volt ? {28'h0, output_voltage_code} :
        hit_stat ? {28'h0, wdog_expired, state == ST_LEVEL,
                    state == ST_EDGE, timeout_flag} :
                   32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // drive decode
    // ------------------------------------------------------------------
    // voltage regulation
    wire vreg = (mode == MODE_VOLTAGE) || force_voltage_mode;
    // torch in mode 01, or strobe-selected in mode 10
    wire torch_level = !wdog_expired && (mode == MODE_VIDEO);
    wire torch_strb  = strobes_on && sel_s && trig_s;
    wire flash_level = strobes_on && running;
    wire shut = (mode == MODE_SHUTDOWN && !force_voltage_mode)
              || wdog_expired;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            currents <= '0;
            drive    <= '0;
        end else begin
            currents                       <= cur;
            drive.shutdown                 <= shut;
            drive.voltage_regulation_state <= vreg;
            drive.torch_on                 <= torch_level || torch_strb;
            drive.flash_on                 <= flash_level;
            drive.output_voltage_code      <= output_voltage_code;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_flash_start;
        starting;
    endsequence

    property p_timeout_clears_soft;
        @(posedge pclk) disable iff (!presetn)
        time_up |=> !soft_flash_start;
    endproperty
    a_timeout_clears_soft: assert property (p_timeout_clears_soft)
        else $error("soft start not cleared by timeout");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        time_up |=> timeout_flag && state == ST_IDLE;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("timeout flag missing");

    property p_edge_holds;
        @(posedge pclk) disable iff (!presetn)
        (state == ST_EDGE && !time_up && strobes_on) |=> state == ST_EDGE;
    endproperty
    a_edge_holds: assert property (p_edge_holds)
        else $error("edge flash ended early");

    property p_level_drop;
        @(posedge pclk) disable iff (!presetn)
        (state == ST_LEVEL && !trig_s) |=> state == ST_IDLE;
    endproperty
    a_level_drop: assert property (p_level_drop)
        else $error("level flash not ended on low strobe");

    property p_video_no_flash;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_VIDEO) |-> !starting;
    endproperty
    a_video_no_flash: assert property (p_video_no_flash)
        else $error("flash started in video mode");

    property p_type_edge;
        @(posedge pclk) disable iff (!presetn)
        (s_flash_start ##0 trigger_type_sel) |=> state == ST_EDGE;
    endproperty
    a_type_edge: assert property (p_type_edge)
        else $error("edge type did not give edge flash");

    property p_vmode_sinks_off;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_VOLTAGE && $past(mode) == MODE_VOLTAGE)
            |=> !drive.torch_on && !drive.flash_on
                && drive.voltage_regulation_state;
    endproperty
    a_vmode_sinks_off: assert property (p_vmode_sinks_off)
        else $error("sinks on in voltage mode");

    property p_wdog_off_flash;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_FLASH) |-> wdog_cnt == 36'h0;
    endproperty
    a_wdog_off_flash: assert property (p_wdog_off_flash)
        else $error("watchdog counting in flash mode");

endmodule : led_flash_mode_control

// ### sim/camera_strobe_model.sv
// Purpose: camera module side driving the two strobe pins
// Assumes: bench commands arrive just after a rising pclk edge
// Notes:   one cycle of lag, as a real camera output register has
`timescale 1ns/10ps

module camera_strobe_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire_cmd,
    input  wire logic torch_cmd,
    output logic      trigger_strobe_in,
    output logic      select_strobe_in
);
    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    // select high asks torch, held high stops watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_strobe_in <= 1'b0;
            select_strobe_in  <= 1'b0;
        end else begin
            trigger_strobe_in <= fire_cmd;
            select_strobe_in  <= torch_cmd;
        end
    end
endmodule : camera_strobe_model

// ### sim/test_led_flash_mode_control.sv
// Purpose: self-checking bench for the flash mode controller
// Assumes: short timer parameters, APB reads noted in a queue
// Notes:   level flash length allows one cycle of synchroniser skew
`timescale 1ns/10ps

module test_led_flash_mode_control;
    import flash_ctrl_pkg::*;
    localparam int unsigned SS = 4;
    localparam int unsigned SL = 8;
    typedef struct { logic [31:0] d; logic [31:0] m; logic e; } note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, r, f;
    logic        trigger_strobe_in, select_strobe_in, fire_cmd, torch_cmd;
    logic [3:0]  cfg [2];
    logic [2:0]  mc [4];
    current_t    currents;
    drive_t      drive;
    note_t       notes [$];
    note_t       cur;
    int          n_mismatch, n_checks, len, i;

    led_flash_mode_control #(.WDOG_LIMIT(100), .STEP_SHORT(SS),
        .STEP_LONG(SL)) i_led_flash_mode_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .trigger_strobe_in(trigger_strobe_in),
        .select_strobe_in(select_strobe_in),
        .currents(currents), .drive(drive));
    camera_strobe_model i_camera_strobe_model (
        .pclk(pclk), .presetn(presetn), .fire_cmd(fire_cmd),
        .torch_cmd(torch_cmd), .trigger_strobe_in(trigger_strobe_in),
        .select_strobe_in(select_strobe_in));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic lost();
        n_mismatch++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        stop_test();
    endtask : lost

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // request held until pready seen high, released at that edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready looked at on the rising edge, request released there
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) lost();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] m, input logic e);
        notes.push_back('{exp & m, m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // expected bits: shutdown, voltage regulation, torch, flash
    task automatic drv(input logic [3:0] exp, output logic [31:0] seen);
        @(negedge pclk);
        seen = {28'h0, drive.shutdown, drive.voltage_regulation_state,
                drive.torch_on, drive.flash_on};
    endtask : drv

    task automatic strobes(input logic fr, input logic tc);
        @(posedge pclk);
        fire_cmd  <= fr;
        torch_cmd <= tc;
    endtask : strobes

    task automatic pulse(input int n);
        strobes(1'b1, 1'b0);
        cyc(n);
        fire_cmd <= 1'b0;
    endtask : pulse

    task automatic flash_len(output int l);
        int k;
        l = 0;
        for (k = 0; k < 100; k++) begin
            @(negedge pclk);
            if (drive.flash_on === 1'b1) break;
        end
        if (k == 100) lost();
        while (drive.flash_on === 1'b1 && l < 400) begin
            l++;
            @(negedge pclk);
        end
    endtask : flash_len

    // ------------------------------------------------------------------
    // read monitor: oldest note against each read answer
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) lost();
            cur = notes.pop_front();
            check(prdata & cur.m, cur.d);
            check({31'h0, pslverr}, {31'h0, cur.e});
        end
    end

    // ------------------------------------------------------------------
    // clock, watchdog on the whole run
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        lost();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;  psel = 1'b0;  penable = 1'b0;  pwrite = 1'b0;
        paddr = 8'h00;  pwdata = 32'h0;  fire_cmd = 1'b0;
        torch_cmd = 1'b0;  seed = 32'h3;  n_mismatch = 0;  n_checks = 0;
        cfg = '{4'h3, 4'ha};
        mc  = '{3'b110, 3'b001, 3'b111, 3'b000};
        cyc(2);
        presetn <= 1'b1;
        cyc(2);
        @(negedge pclk);
        check(32'(currents), 32'({RST_TORCH_OUTER, RST_TORCH_CENTRE,
              RST_FLASH_CENTRE, RST_FLASH_OUTER}));
        check(32'(drive.output_voltage_code), 32'(RST_VOLT_CODE));
        drv(4'b1000, r);
        check(r, 32'h8);
        rd(ADDR_TORCH, 32'h12, 32'hffffffff, 1'b0);
        rd(ADDR_FLASHC, 32'h0810, 32'hffffffff, 1'b0);
        rd(ADDR_TIMING, 32'h04, 32'hffffffff, 1'b0);
        rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
        for (i = 0; i < 4; i++) begin
            r = next_rand();
            f = next_rand();
            wr(ADDR_TORCH, r);
            wr(ADDR_FLASHC, f);
            wr(ADDR_VOLT, r >> 8);
            rd(ADDR_TORCH, r & 32'h3f, 32'hffffffff, 1'b0);
            rd(ADDR_FLASHC, f & 32'h1f3f, 32'hffffffff, 1'b0);
            rd(ADDR_VOLT, (r >> 8) & 32'hf, 32'hffffffff, 1'b0);
            @(negedge pclk);
            check(32'(currents), {15'h0, r[5:0], f[5:0], f[12:8]});
            check(32'(drive.output_voltage_code), 32'(r[11:8]));
        end
        // mode and force combinations without light
        for (i = 0; i < 4; i++) begin
            wr(ADDR_MODE, {24'h0, mc[i][2:1], 5'h0, mc[i][0]});
            cyc(3);
            drv((mc[i] == 3'b000) ? 4'b1000 : 4'b0100, r);
            check(r, (mc[i] == 3'b000) ? 32'h8 : 32'h4);
        end
        // video light: trigger and soft start have no say, select held high stops the watchdog
        strobes(1'b1, 1'b0);
        wr(ADDR_MODE, 32'h40);
        wr(ADDR_TIMING, 32'h90);
        cyc(6);
        drv(4'b0010, r);
        check(r, 32'h2);
        wr(ADDR_TIMING, 32'h10);
        strobes(1'b0, 1'b0);
        cyc(150);
        drv(4'b1000, r);
        check(r, 32'h8);
        wr(ADDR_MODE, 32'h41);
        cyc(3);
        drv(4'b0110, r);
        check(r, 32'h6);
        strobes(1'b0, 1'b1);
        cyc(150);
        drv(4'b0110, r);
        check(r, 32'h6);
        // flash mode: torch by select, no watchdog, force keeps voltage
        wr(ADDR_MODE, 32'h80);
        strobes(1'b1, 1'b1);
        cyc(6);
        drv(4'b0010, r);
        check(r, 32'h2);
        cyc(150);
        drv(4'b0010, r);
        check(r, 32'h2);
        strobes(1'b0, 1'b1);
        strobes(1'b0, 1'b0);
        wr(ADDR_MODE, 32'h81);
        cyc(3);
        drv(4'b0100, r);
        check(r, 32'h4);
        wr(ADDR_MODE, 32'h80);
        // edge flashes with a retrigger inside each
        for (i = 0; i < 2; i++) begin
            wr(ADDR_TIMING, 32'h10 | 32'(cfg[i]));
            fork
                flash_len(len);
                begin
                    pulse(3);
                    cyc(5);
                    pulse(3);
                end
            join
            check(32'(len), 32'((cfg[i][2:0] + 1) *
                  (cfg[i][3] ? SL : SS)));
            rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
        end
        // soft start, cleared again by the timeout
        fork
            wr(ADDR_TIMING, 32'h92);
            flash_len(len);
        join
        check(32'(len), 32'(3 * SS));
        rd(ADDR_TIMING, 32'h12, 32'hff, 1'b0);
        // level flash held past the timer, status read mid-flash
        wr(ADDR_TIMING, 32'h02);
        fork
            flash_len(len);
            pulse(40);
            begin
                cyc(8);
                rd(ADDR_STATUS, 32'h4, 32'h5, 1'b0);
            end
        join
        check(32'(len), 32'(3 * SS));
        // level flash ended by the strobe
        wr(ADDR_TIMING, 32'h07);
        fork
            flash_len(len);
            pulse(10);
        join
        check(32'(len >= 9 && len <= 11), 32'h1);
        stop_test();
    end
endmodule : test_led_flash_mode_control
